// >>> rtl/csfg_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the CPU housekeeping block.
// Assumes: Register indices are multiplied by four to form APB byte addresses.
// Notes:   Definitions only; include by bare name.
`ifndef CSFG_DEFS_SVH
`define CSFG_DEFS_SVH

// Register indices and byte addresses.
`define CSFG_IDX_GUARD      10'h004
`define CSFG_IDX_SPL        10'h00d
`define CSFG_IDX_SPH        10'h00e
`define CSFG_IDX_RESULT_FLAG_REGISTER       10'h00f
`define CSFG_ADDR_GUARD     {`CSFG_IDX_GUARD, 2'b00}
`define CSFG_ADDR_SPL       {`CSFG_IDX_SPL, 2'b00}
`define CSFG_ADDR_SPH       {`CSFG_IDX_SPH, 2'b00}
`define CSFG_ADDR_RESULT_FLAG_REGISTER      {`CSFG_IDX_RESULT_FLAG_REGISTER, 2'b00}

// Guard signatures and read-back bits.
`define CSFG_KEY_IO         8'hd8
`define CSFG_KEY_SELFPROG   8'h9d
`define CSFG_GUARD_IO_BIT   0
`define CSFG_GUARD_SPM_BIT  1

// Result-flag register bit positions.
`define CSFG_FLAG_I         7
`define CSFG_FLAG_T         6
`define CSFG_FLAG_H         5
`define CSFG_FLAG_S         4
`define CSFG_FLAG_V         3
`define CSFG_FLAG_N         2
`define CSFG_FLAG_Z         1
`define CSFG_FLAG_C         0

// Reset values.
`define CSFG_RESULT_FLAG_REGISTER_RESET     8'h00
`define CSFG_SRAM_TOP       16'h7fff

// Instructions a guard or stack-pointer window stays open.
`define CSFG_WINDOW_INSTRS  3'h4

// First register of the first pointer pair, and the low and high bytes of Z.
`define CSFG_REG_PTR_BASE   5'h1a
`define CSFG_REG_Z_LO       5'h1e
`define CSFG_REG_Z_HI       5'h1f

`endif

// >>> rtl/csfg_pkg.sv
// Purpose: Types shared by the CPU housekeeping block.
// Assumes: Nothing is imported; users write csfg_pkg::name.
// Notes:   Codes are one-hot.
package csfg_pkg;

    typedef enum logic [4:0] {
        CSFG_OP_NONE = 5'h01,
        CSFG_OP_PUSH = 5'h02,
        CSFG_OP_POP  = 5'h04,
        CSFG_OP_CALL = 5'h08,
        CSFG_OP_RET  = 5'h10
    } csfg_stack_op_t;

    typedef enum logic [3:0] {
        CSFG_PTR_NONE    = 4'h1,
        CSFG_PTR_DISP    = 4'h2,
        CSFG_PTR_POSTINC = 4'h4,
        CSFG_PTR_PREDEC  = 4'h8
    } csfg_ptr_mode_t;

endpackage : csfg_pkg

// >>> rtl/csfg_guard_window.sv
// Purpose: Window that opens on a start pulse and closes after a count of instructions.
// Assumes: tick pulses once per executed instruction.
// Notes:   Start beats kill, so a reopening write is never lost.
`timescale 1ns/1ps
`include "csfg_defs.svh"
module csfg_guard_window #(
    parameter logic [2:0] LIMIT = `CSFG_WINDOW_INSTRS
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset_n,
    // Events.
    input  wire logic start,
    input  wire logic kill,
    input  wire logic tick,
    // State.
    output logic      windowOpen,
    output logic      next_windowOpen
);

    logic [2:0] count;
    logic [2:0] next_count;

    always_comb
    begin
        next_windowOpen = windowOpen;
        next_count      = count;
        if (start)
        begin
            next_windowOpen = 1'b1;
            next_count      = 3'h0;
        end
        else if (kill)
        begin
            next_windowOpen = 1'b0;
            next_count      = 3'h0;
        end
        else if (windowOpen && tick)
        begin
            if (count == LIMIT - 3'h1)
            begin
                next_windowOpen = 1'b0;
                next_count      = 3'h0;
            end
            else
            begin
                next_count = count + 3'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            windowOpen <= 1'b0;
            count      <= 3'h0;
        end
        else
        begin
            windowOpen <= next_windowOpen;
            count      <= next_count;
        end
    end

endmodule : csfg_guard_window

// >>> rtl/csfg_regfile.sv
// Purpose: Working register file with pointer pairs and registered read ports.
// Assumes: One write and two reads per cycle; reads return one cycle later.
// Notes:   An explicit write to a pointer byte beats that pointer's own update.
`timescale 1ns/1ps
`include "csfg_defs.svh"
module csfg_regfile (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Register access.
    input  wire logic                     wrEn,
    input  wire logic [4:0]               wrAddr,
    input  wire logic [7:0]               wrData,
    input  wire logic                     immOp,
    input  wire logic [4:0]               rdAddrA,
    input  wire logic [4:0]               rdAddrB,
    output logic      [7:0]               rdDataA,
    output logic      [7:0]               rdDataB,
    // Pointer addressing.
    input  wire logic                     ptrReq,
    input  wire logic [1:0]               ptrSel,
    input  wire csfg_pkg::csfg_ptr_mode_t ptrMode,
    input  wire logic [5:0]               ptrDisp,
    output logic      [15:0]              ptrDataAddr,
    output logic      [15:0]              ptrProgAddr,
    output logic                          ptrValid
);

    logic [7:0]  regs [0:31];
    logic [4:0]  effWr;
    logic [4:0]  effRdA;
    logic [4:0]  ptrLo;
    logic [4:0]  ptrHi;
    logic [15:0] ptrVal;
    logic [15:0] next_ptr;
    logic [15:0] effAddr;

    assign effWr  = immOp ? {1'b1, wrAddr[3:0]} : wrAddr;
    assign effRdA = immOp ? {1'b1, rdAddrA[3:0]} : rdAddrA;
    assign ptrLo  = `CSFG_REG_PTR_BASE + {2'b00, ptrSel, 1'b0};
    assign ptrHi  = ptrLo + 5'h01;
    assign ptrVal = {regs[ptrHi], regs[ptrLo]};

    always_comb
    begin
        next_ptr = ptrVal;
        effAddr  = ptrVal;
        case (ptrMode)
            csfg_pkg::CSFG_PTR_DISP:    effAddr = ptrVal + {10'h000, ptrDisp};
            csfg_pkg::CSFG_PTR_POSTINC: next_ptr = ptrVal + 16'h0001;
            csfg_pkg::CSFG_PTR_PREDEC:
            begin
                next_ptr = ptrVal - 16'h0001;
                effAddr  = ptrVal - 16'h0001;
            end
            default:                    effAddr = ptrVal;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 32; i++)
            begin
                regs[i] <= 8'h00;
            end
        end
        else
        begin
            if (ptrReq && (ptrMode == csfg_pkg::CSFG_PTR_POSTINC || ptrMode == csfg_pkg::CSFG_PTR_PREDEC))
            begin
                regs[ptrLo] <= next_ptr[7:0];
                regs[ptrHi] <= next_ptr[15:8];
            end
            if (wrEn)
            begin
                regs[effWr] <= wrData;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rdDataA     <= 8'h00;
            rdDataB     <= 8'h00;
            ptrDataAddr <= 16'h0000;
            ptrProgAddr <= 16'h0000;
            ptrValid    <= 1'b0;
        end
        else
        begin
            rdDataA     <= regs[effRdA];
            rdDataB     <= regs[rdAddrB];
            ptrDataAddr <= effAddr;
            ptrProgAddr <= {regs[`CSFG_REG_Z_HI], regs[`CSFG_REG_Z_LO]};
            ptrValid    <= ptrReq;
        end
    end

endmodule : csfg_regfile

// >>> rtl/csfg_core.sv
// Purpose: CPU housekeeping: result flags, stack pointer, register file and change guard.
// Assumes: CPU-side inputs are synchronous single-cycle pulses; APB is zero-wait.
// Notes:   Registers sit at four times their index on the APB.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "csfg_defs.svh"
module csfg_core #(
    parameter logic [15:0] SRAM_TOP = `CSFG_SRAM_TOP
) (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // CPU events.
    input  wire logic                     instrDone,
    input  wire logic                     ioWrite,
    input  wire logic                     nvmAccess,
    input  wire logic                     sleepExec,
    // ALU results.
    input  wire logic                     aluValid,
    input  wire logic                     aluHalf,
    input  wire logic                     aluOverflow,
    input  wire logic                     aluNegative,
    input  wire logic                     aluZero,
    input  wire logic                     aluCarry,
    // Stack requests.
    input  wire csfg_pkg::csfg_stack_op_t stackOp,
    input  wire logic [7:0]               pushData,
    input  wire logic [16:0]              returnAddr,
    // Stack memory side.
    output logic                          stackWrEn,
    output logic                          stackWrWord,
    output logic      [15:0]              stackWrAddr,
    output logic      [15:0]              stackWrData,
    output logic                          stackRdEn,
    output logic                          stackRdWord,
    output logic      [15:0]              stackRdAddr,
    output logic      [15:0]              stackPointer,
    // Register file.
    input  wire logic                     rfWrEn,
    input  wire logic [4:0]               rfWrAddr,
    input  wire logic [7:0]               rfWrData,
    input  wire logic                     rfImmOp,
    input  wire logic [4:0]               rfRdAddrA,
    input  wire logic [4:0]               rfRdAddrB,
    output logic      [7:0]               rfRdDataA,
    output logic      [7:0]               rfRdDataB,
    input  wire logic                     ptrReq,
    input  wire logic [1:0]               ptrSel,
    input  wire csfg_pkg::csfg_ptr_mode_t ptrMode,
    input  wire logic [5:0]               ptrDisp,
    output logic      [15:0]              ptrDataAddr,
    output logic      [15:0]              ptrProgAddr,
    output logic                          ptrValid,
    // Guard and flags.
    output logic                          ioUnlock,
    output logic                          selfProgUnlock,
    output logic                          irqBlock,
    output logic      [7:0]               resultFlags
);

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic        setupPhase;
    logic        accessWrite;
    logic        lowLane;
    logic        wrGuard;
    logic        wrSpl;
    logic        wrSph;
    logic        wrSreg;
    logic        wrOther;
    logic [7:0]  wrByte;
    logic        hitGuard;
    logic        hitSpl;
    logic        hitSph;
    logic        hitSreg;
    logic        addrHit;

    assign setupPhase  = psel && !penable;
    // The slave is zero-wait, so every access phase completes.
    assign accessWrite = psel && penable && pwrite && !pslverr;
    assign lowLane     = pstrb[0];
    assign wrByte      = pwdata[7:0];
    assign hitGuard    = (paddr == `CSFG_ADDR_GUARD);
    assign hitSpl      = (paddr == `CSFG_ADDR_SPL);
    assign hitSph      = (paddr == `CSFG_ADDR_SPH);
    assign hitSreg     = (paddr == `CSFG_ADDR_RESULT_FLAG_REGISTER);
    assign addrHit     = hitGuard || hitSpl || hitSph || hitSreg;
    assign wrGuard     = accessWrite && lowLane && hitGuard;
    assign wrSpl       = accessWrite && lowLane && hitSpl;
    assign wrSph       = accessWrite && lowLane && hitSph;
    assign wrSreg      = accessWrite && lowLane && hitSreg;
    // Every software write to a mapped register other than the guard counts as an I/O write.
    assign wrOther     = (accessWrite && !hitGuard) || ioWrite;

    ////////////////////////////////////////////////////////////////////////////
    // Change guard.

    logic keyIo;
    logic keySelfProg;
    logic ioOpen;
    logic ioOpenNext;
    logic spmOpen;
    logic spmOpenNext;
    logic splHold;
    logic splHoldNext;

    assign keyIo       = wrGuard && (wrByte == `CSFG_KEY_IO);
    assign keySelfProg = wrGuard && (wrByte == `CSFG_KEY_SELFPROG);

    // Any other guard value matches neither key and opens nothing.
    csfg_guard_window #(
        .LIMIT (`CSFG_WINDOW_INSTRS)
    ) u_io_window (
        .clk             (clk),
        .reset_n         (reset_n),
        .start           (keyIo),
        .kill            (wrOther || nvmAccess || sleepExec || keySelfProg),
        .tick            (instrDone),
        .windowOpen      (ioOpen),
        .next_windowOpen (ioOpenNext)
    );

    csfg_guard_window #(
        .LIMIT (`CSFG_WINDOW_INSTRS)
    ) u_spm_window (
        .clk             (clk),
        .reset_n         (reset_n),
        .start           (keySelfProg),
        .kill            (nvmAccess || sleepExec || keyIo),
        .tick            (instrDone),
        .windowOpen      (spmOpen),
        .next_windowOpen (spmOpenNext)
    );

    // A later I/O write or the fourth instruction ends the hold, never the low-byte write itself.
    csfg_guard_window #(
        .LIMIT (`CSFG_WINDOW_INSTRS)
    ) u_spl_hold (
        .clk             (clk),
        .reset_n         (reset_n),
        .start           (wrSpl),
        .kill            (wrOther),
        .tick            (instrDone),
        .windowOpen      (splHold),
        .next_windowOpen (splHoldNext)
    );

    // The block only withholds service; interrupt flags stay pending outside.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ioUnlock       <= 1'b0;
            selfProgUnlock <= 1'b0;
            irqBlock       <= 1'b0;
        end
        else
        begin
            ioUnlock       <= ioOpenNext;
            selfProgUnlock <= spmOpenNext;
            irqBlock       <= ioOpenNext || spmOpenNext || splHoldNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result flags.

    logic [7:0] next_flags;

    always_comb
    begin
        next_flags = resultFlags;
        if (wrSreg)
        begin
            next_flags = wrByte;
        end
        if (aluValid)
        begin
            next_flags[`CSFG_FLAG_H] = aluHalf;
            next_flags[`CSFG_FLAG_V] = aluOverflow;
            next_flags[`CSFG_FLAG_N] = aluNegative;
            next_flags[`CSFG_FLAG_Z] = aluZero;
            next_flags[`CSFG_FLAG_C] = aluCarry;
        end
        next_flags[`CSFG_FLAG_S] = next_flags[`CSFG_FLAG_N] ^ next_flags[`CSFG_FLAG_V];
    end

    // Stack operations never touch the flags; handlers save them in software.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            resultFlags <= `CSFG_RESULT_FLAG_REGISTER_RESET;
        end
        else
        begin
            resultFlags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack pointer.

    logic [15:0] returnWord;
    logic [15:0] next_sp;

    assign returnWord = returnAddr[16:1];

    // A software write to either byte beats a stack operation in the same cycle.
    always_comb
    begin
        next_sp = stackPointer;
        if (wrSpl || wrSph)
        begin
            if (wrSpl)
            begin
                next_sp[7:0] = wrByte;
            end
            if (wrSph)
            begin
                next_sp[15:8] = wrByte;
            end
        end
        else
        begin
            case (stackOp)
                csfg_pkg::CSFG_OP_PUSH: next_sp = stackPointer - 16'h0001;
                csfg_pkg::CSFG_OP_POP:  next_sp = stackPointer + 16'h0001;
                csfg_pkg::CSFG_OP_CALL: next_sp = stackPointer - 16'h0002;
                csfg_pkg::CSFG_OP_RET:  next_sp = stackPointer + 16'h0002;
                default:                next_sp = stackPointer;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stackPointer <= SRAM_TOP;
        end
        else
        begin
            stackPointer <= next_sp;
        end
    end

    // Stack memory strobes; data byte 0 goes to the address, byte 1 to the address plus one.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stackWrEn   <= 1'b0;
            stackWrWord <= 1'b0;
            stackWrAddr <= 16'h0000;
            stackWrData <= 16'h0000;
            stackRdEn   <= 1'b0;
            stackRdWord <= 1'b0;
            stackRdAddr <= 16'h0000;
        end
        else
        begin
            stackWrEn   <= 1'b0;
            stackWrWord <= 1'b0;
            stackRdEn   <= 1'b0;
            stackRdWord <= 1'b0;
            if (!(wrSpl || wrSph))
            begin
                case (stackOp)
                    csfg_pkg::CSFG_OP_PUSH:
                    begin
                        stackWrEn   <= 1'b1;
                        stackWrAddr <= stackPointer;
                        stackWrData <= {8'h00, pushData};
                    end
                    csfg_pkg::CSFG_OP_CALL:
                    begin
                        stackWrEn   <= 1'b1;
                        stackWrWord <= 1'b1;
                        stackWrAddr <= stackPointer - 16'h0001;
                        stackWrData <= {returnWord[7:0], returnWord[15:8]};
                    end
                    csfg_pkg::CSFG_OP_POP:
                    begin
                        stackRdEn   <= 1'b1;
                        stackRdAddr <= stackPointer + 16'h0001;
                    end
                    csfg_pkg::CSFG_OP_RET:
                    begin
                        stackRdEn   <= 1'b1;
                        stackRdWord <= 1'b1;
                        stackRdAddr <= stackPointer + 16'h0001;
                    end
                    default:
                    begin
                        stackWrEn <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer.

    // Read data is captured in the setup cycle; a stack move in that cycle shows next read.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (setupPhase)
            begin
                pslverr <= !addrHit;
                if (hitGuard)
                begin
                    prdata <= {30'h00000000, spmOpen, ioOpen};
                end
                else if (hitSpl)
                begin
                    prdata <= {24'h000000, stackPointer[7:0]};
                end
                else if (hitSph)
                begin
                    prdata <= {24'h000000, stackPointer[15:8]};
                end
                else if (hitSreg)
                begin
                    prdata <= {24'h000000, resultFlags};
                end
                else
                begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Working registers.

    csfg_regfile u_regfile (
        .clk         (clk),
        .reset_n     (reset_n),
        .wrEn        (rfWrEn),
        .wrAddr      (rfWrAddr),
        .wrData      (rfWrData),
        .immOp       (rfImmOp),
        .rdAddrA     (rfRdAddrA),
        .rdAddrB     (rfRdAddrB),
        .rdDataA     (rfRdDataA),
        .rdDataB     (rfRdDataB),
        .ptrReq      (ptrReq),
        .ptrSel      (ptrSel),
        .ptrMode     (ptrMode),
        .ptrDisp     (ptrDisp),
        .ptrDataAddr (ptrDataAddr),
        .ptrProgAddr (ptrProgAddr),
        .ptrValid    (ptrValid)
    );

endmodule : csfg_core

// >>> sim/csfg_core_sva.sv
// Purpose: Port checks.
// Assumes: One clock.
// Notes:   Bound from bench.
`timescale 1ns/1ps
`include "csfg_defs.svh"
module csfg_core_sva (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        reset_n,
    // Observed ports.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        sleepExec,
    input wire logic [4:0]  stackOp,
    input wire logic [15:0] stackPointer,
    input wire logic        ioUnlock,
    input wire logic        selfProgUnlock,
    input wire logic        irqBlock,
    input wire logic [7:0]  resultFlags
);
    logic apbWr;
    logic guardWr;
    assign apbWr = psel && penable && pwrite;
    assign guardWr = apbWr && paddr == `CSFG_ADDR_GUARD && pstrb[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_push_step: assert property (stackOp == csfg_pkg::CSFG_OP_PUSH && !apbWr
        |=> stackPointer == $past(stackPointer) - 16'h1) else $error("push step wrong");
    a_call_step: assert property (stackOp == csfg_pkg::CSFG_OP_CALL && !apbWr
        |=> stackPointer == $past(stackPointer) - 16'h2) else $error("call step wrong");
    a_io_key: assert property (guardWr && pwdata[7:0] == `CSFG_KEY_IO
        |=> ioUnlock && irqBlock) else $error("io key did not open");
    a_spm_key: assert property (guardWr && pwdata[7:0] == `CSFG_KEY_SELFPROG
        |=> selfProgUnlock) else $error("spm key did not open");
    a_sleep_close: assert property (ioUnlock && sleepExec && !guardWr
        |=> !ioUnlock) else $error("sleep kept window");
    a_other_key: assert property (guardWr && !ioUnlock && !selfProgUnlock
        && !(pwdata[7:0] inside {`CSFG_KEY_IO, `CSFG_KEY_SELFPROG})
        |=> !(ioUnlock || selfProgUnlock)) else $error("bad key opened");
    a_sign_xor: assert property (resultFlags[4] == (resultFlags[2] ^ resultFlags[3]))
        else $error("sign flag wrong");
    a_window_irq: assert property (ioUnlock || selfProgUnlock |-> irqBlock)
        else $error("irq not blocked");
endmodule : csfg_core_sva

// >>> sim/tb_csfg_core.sv
// Purpose: Bench for csfg_core.
// Assumes: One clock.
// Notes:   Queued results.
`timescale 1ns/1ps
`include "csfg_defs.svh"
`define CHK(n, e, a) begin nChecks++; \
    if ((a) !== (e)) begin numErrors++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module tb_csfg_core;
    localparam logic [15:0] TOP = 16'h3fff;
    logic                     clk = '0, reset_n = '0, psel = '0, penable = '0, pwrite = '0;
    logic                     instrDone = '0, ioWrite = '0, nvmAccess = '0, sleepExec = '0;
    logic                     aluValid = '0, aluHalf, aluOverflow, aluNegative;
    logic                     aluZero, aluCarry, rfWrEn = '0, rfImmOp = '0, ptrReq = '0;
    logic                     pready, pslverr, stackWrEn, stackWrWord, ptrValid, irqBlock;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, wQ[$], e32;
    logic [3:0]               pstrb = 4'h1;
    logic [7:0]               pushData, rfWrData;
    logic [16:0]              returnAddr;
    logic [4:0]               rfWrAddr, rfRdAddrA = '0, rfRdAddrB = '0, f;
    logic [1:0]               ptrSel = 2'h2;
    logic [5:0]               ptrDisp = 6'h05;
    logic [15:0]              stackWrAddr, stackWrData, ptrDataAddr, ptrProgAddr, pQ[$], e16;
    logic [32:0]              rdQ[$], e33;
    csfg_pkg::csfg_stack_op_t stackOp = csfg_pkg::CSFG_OP_NONE;
    csfg_pkg::csfg_ptr_mode_t ptrMode = csfg_pkg::CSFG_PTR_NONE;
    int                       numErrors = 0, nChecks = 0;
    csfg_core #(.SRAM_TOP(TOP)) u_csfg_core (.*, .stackRdEn(), .stackRdWord(), .stackRdAddr(),
        .stackPointer(), .rfRdDataA(), .rfRdDataB(), .ioUnlock(), .selfProgUnlock(), .resultFlags());
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite && rdQ.size() > 0)
        begin
            e33 = rdQ.pop_front();
            `CHK("prdata", e33, {pslverr, prdata})
        end
        if (stackWrEn && stackWrWord && wQ.size() > 0)
        begin
            e32 = wQ.pop_front();
            `CHK("stack word", e32, {stackWrAddr, stackWrData})
        end
        if (ptrValid && pQ.size() > 0)
        begin
            e16 = pQ.pop_front();
            `CHK("pointer", e16, ptrDataAddr)
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (!pready && ++k < 50);
        if (k >= 50)
        begin
            numErrors++;
            giveVerdict();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rdQ.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk);
            instrDone <= 1'b1;
            @(posedge clk);
            instrDone <= 1'b0;
        end
    endtask : ticks
    task automatic stk(input csfg_pkg::csfg_stack_op_t op, input logic [16:0] ra);
        @(posedge clk);
        stackOp    <= op;
        returnAddr <= ra;
        pushData   <= 8'($urandom);
        @(posedge clk);
        stackOp    <= csfg_pkg::CSFG_OP_NONE;
    endtask : stk
    task automatic giveVerdict();
        $display("Checks %0d, errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : giveVerdict
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(11));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(`CSFG_ADDR_SPL, {25'h0, TOP[7:0]});
        rd(`CSFG_ADDR_SPH, {25'h0, TOP[15:8]});
        rd(12'h000, {1'b1, 32'h0});
        apb(`CSFG_ADDR_GUARD, 1'b1, 32'h55);
        rd(`CSFG_ADDR_GUARD, 33'h0);
        apb(`CSFG_ADDR_GUARD, 1'b1, `CSFG_KEY_IO);
        rd(`CSFG_ADDR_GUARD, 33'h1);
        ticks(4);
        rd(`CSFG_ADDR_GUARD, 33'h0);
        apb(`CSFG_ADDR_GUARD, 1'b1, `CSFG_KEY_SELFPROG);
        rd(`CSFG_ADDR_GUARD, 33'h2);
        @(posedge clk);
        nvmAccess <= 1'b1;
        @(posedge clk);
        nvmAccess <= 1'b0;
        rd(`CSFG_ADDR_GUARD, 33'h0);
        apb(`CSFG_ADDR_GUARD, 1'b1, `CSFG_KEY_IO);
        @(posedge clk);
        sleepExec <= 1'b1;
        @(posedge clk);
        sleepExec <= 1'b0;
        rd(`CSFG_ADDR_GUARD, 33'h0);
        repeat (4)
        begin
            f = 5'($urandom);
            @(posedge clk);
            aluValid <= 1'b1;
            {aluHalf, aluOverflow, aluNegative, aluZero, aluCarry} <= f;
            @(posedge clk);
            aluValid <= 1'b0;
            rd(`CSFG_ADDR_RESULT_FLAG_REGISTER, {27'h0, f[4], f[3] ^ f[2], f[3:0]});
        end
        apb(`CSFG_ADDR_SPH, 1'b1, 32'h01);
        apb(`CSFG_ADDR_SPL, 1'b1, 32'h40);
        @(negedge clk);
        `CHK("hold", 1'b1, irqBlock)
        ticks(4);
        @(negedge clk);
        `CHK("hold", 1'b0, irqBlock)
        stk(csfg_pkg::CSFG_OP_PUSH, 17'h0);
        rd(`CSFG_ADDR_SPL, 33'h03f);
        stk(csfg_pkg::CSFG_OP_POP, 17'h0);
        rd(`CSFG_ADDR_SPL, 33'h040);
        wQ.push_back({16'h013f, 16'h0300});
        stk(csfg_pkg::CSFG_OP_CALL, 17'h00006);
        rd(`CSFG_ADDR_SPL, 33'h03e);
        stk(csfg_pkg::CSFG_OP_RET, 17'h0);
        rd(`CSFG_ADDR_SPL, 33'h040);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            rfWrEn   <= 1'b1;
            rfWrAddr <= `CSFG_REG_Z_LO + 5'(i);
            rfWrData <= i ? 8'h12 : 8'h34;
        end
        for (int i = 0; i < 3; i++)
        begin
            pQ.push_back(i == 0 ? 16'h1239 : 16'h1234);
            @(posedge clk);
            rfWrEn  <= 1'b0;
            ptrReq  <= 1'b1;
            ptrMode <= csfg_pkg::csfg_ptr_mode_t'(4'h2 << i);
        end
        @(posedge clk);
        ptrReq <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("program pointer", 16'h1234, ptrProgAddr)
        giveVerdict();
    end
endmodule : tb_csfg_core
bind csfg_core csfg_core_sva u_csfg_core_sva (.*);
